// ---- ccp_pkg.sv ----
// Shared types and constants for the configuration daisy-chain port.
package ccp_pkg;

	// ----------------------------------------
	// Constants
	// ----------------------------------------
	localparam int CCP_BYTE_W = 8;
	localparam int CCP_SYNC_STAGES = 3;
	localparam int CCP_PIN_CLK = 0;
	localparam int CCP_PIN_DATA = 1;
	localparam int CCP_PIN_SEL = 2;
	localparam int CCP_PIN_BUS = 3;
	localparam logic CCP_RESET_LOW = 1'b0;
	localparam logic CCP_OE_DRIVE = 1'b0;
	localparam logic CCP_OE_RELEASE = 1'b1;
	localparam logic CCP_VARIANT_EIGHT_GLOBAL = 1'b0;
	localparam logic CCP_VARIANT_FOUR_SECONDARY = 1'b1;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		CCP_IDLE = 2'h0,
		CCP_LOAD = 2'h1,
		CCP_PASS = 2'h3,
		CCP_DONE = 2'h2
	} ccp_state_e;

	typedef struct packed {
		logic out;
		logic oe_n;
	} ccp_pin_s;

	typedef struct packed {
		logic [CCP_BYTE_W-1:0] data;
		logic valid;
	} ccp_byte_s;

endpackage

// ---- ccp_pin_sync.sv ----
// Three-stage pin synchroniser with stable value and edge pulses.
`timescale 1ns/1ps
module ccp_pin_sync
	import ccp_pkg::*;
#(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_arst_n,
	// Pin side
	input wire logic [W-1:0] i_pin,
	// Synchronised side
	output logic [W-1:0] o_level,
	output logic [W-1:0] o_rise,
	output logic [W-1:0] o_fall
);

	// ----------------------------------------
	// Synchroniser
	// ----------------------------------------
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;
	logic [W-1:0] level;
	logic [W-1:0] next_level;
	logic [W-1:0] rise;
	logic [W-1:0] fall;
	logic [W-1:0] next_rise;
	logic [W-1:0] next_fall;

	// A change counts only once the second and third stages agree.
	always_comb begin
		next_level = level;
		next_rise = '0;
		next_fall = '0;
		for (int k = 0; k < W; k++) begin
			if (stage2[k] == stage3[k] && stage3[k] != level[k]) begin
				next_level[k] = stage3[k];
				next_rise[k] = stage3[k];
				next_fall[k] = ~stage3[k];
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (i_arst_n == CCP_RESET_LOW) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			level <= '0;
			rise <= '0;
			fall <= '0;
		end else begin
			stage1 <= i_pin;
			stage2 <= stage1;
			stage3 <= stage2;
			level <= next_level;
			rise <= next_rise;
			fall <= next_fall;
		end
	end

	assign o_level = level;
	assign o_rise = rise;
	assign o_fall = fall;

endmodule // ccp_pin_sync

// ---- ccp_config_port.sv ----
// Configuration-time data port: serial chaining and byte-wide daisy chain.
// Behaviour
// - Serial modes sample the serial data input on each config clock rising edge.
// - Serial modes forward received data onto the chain output for downstream devices.
// - Chain output changes on a falling edge, 1.5 periods after sampling.
// - Byte-wide mode takes configuration data on eight parallel input pins.
// - In byte-wide mode chain select enables this device to accept data; upstream drives it.
// - Byte-wide mode chain output is status enabling the next device.
// - Chain output appears on global input six or secondary input four by variant.
// - After configuration the serial data pin is released to user I/O.
// - After configuration the eight byte pins are released to user I/O.
// - After configuration the chain output pin stops driving, becomes user I/O.
// - Until configuration completes every user pin has a weak pull-up.
// - During configuration a data error drives the active-low init pin low.
`timescale 1ns/1ps
module ccp_config_port
	import ccp_pkg::*;
#(
	parameter logic VARIANT = CCP_VARIANT_EIGHT_GLOBAL,
	parameter int BYTE_W = CCP_BYTE_W
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_arst_n,
	// Configuration control from the loader core
	input wire logic i_start,
	input wire logic i_byte_mode,
	input wire logic i_own_loaded,
	input wire logic i_config_done,
	input wire logic i_data_error,
	// Configuration pins
	input wire logic i_config_clock,
	input wire logic i_serial_data,
	input wire logic i_chain_select_in,
	input wire logic [BYTE_W-1:0] i_config_byte_bus,
	// Pin drive and release
	output logic o_global_input_six,
	output logic o_global_input_six_oe_n,
	output logic o_secondary_global_input_four,
	output logic o_secondary_global_input_four_oe_n,
	output logic o_init_n,
	output logic o_init_oe_n,
	output logic o_pullup_en,
	output logic o_user_io_release,
	// Received data to the loader core
	output logic o_bit,
	output logic o_bit_valid,
	output logic [BYTE_W-1:0] o_byte,
	output logic o_byte_valid,
	output logic o_busy
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	localparam int NPIN = BYTE_W + CCP_PIN_BUS;
	logic [NPIN-1:0] pin_level;
	logic [NPIN-1:0] pin_rise;
	logic [NPIN-1:0] pin_fall;
	logic clk_rise;
	logic clk_fall;
	logic din_level;
	logic sel_level;
	logic [BYTE_W-1:0] bus_level;

	// All pins share one delay so data stays aligned with the clock edges.
	ccp_pin_sync #(
		.W(NPIN)
	) u_sync (
		.i_mclk(i_mclk),
		.i_arst_n(i_arst_n),
		.i_pin({i_config_byte_bus, i_chain_select_in, i_serial_data, i_config_clock}),
		.o_level(pin_level),
		.o_rise(pin_rise),
		.o_fall(pin_fall)
	);

	assign clk_rise = pin_rise[CCP_PIN_CLK];
	assign clk_fall = pin_fall[CCP_PIN_CLK];
	assign din_level = pin_level[CCP_PIN_DATA];
	assign sel_level = pin_level[CCP_PIN_SEL];
	assign bus_level = pin_level[NPIN-1:CCP_PIN_BUS];

	// ----------------------------------------
	// State machine
	// ----------------------------------------
	ccp_state_e state;
	ccp_state_e next_state;

	always_comb begin
		next_state = state;
		case (state)
			CCP_IDLE: begin
				if (i_start) begin
					next_state = CCP_LOAD;
				end
			end
			CCP_LOAD: begin
				if (i_config_done) begin
					next_state = CCP_DONE;
				end else if (i_own_loaded) begin
					next_state = CCP_PASS;
				end
			end
			CCP_PASS: begin
				if (i_config_done) begin
					next_state = CCP_DONE;
				end
			end
			CCP_DONE: begin
				next_state = CCP_DONE;
			end
			default: begin
				next_state = CCP_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (i_arst_n == CCP_RESET_LOW) begin
			state <= CCP_IDLE;
		end else begin
			state <= next_state;
		end
	end

	logic active;
	assign active = (state == CCP_LOAD) || (state == CCP_PASS);

	// ----------------------------------------
	// Data path
	// ----------------------------------------
	logic hold_a;
	logic hold_b;
	logic chain_data;
	logic bit_q;
	logic bit_valid;
	ccp_byte_s byte_q;
	logic next_hold_a;
	logic next_hold_b;
	logic next_chain_data;
	logic next_bit_q;
	logic next_bit_valid;
	ccp_byte_s next_byte_q;

	always_comb begin
		next_hold_a = hold_a;
		next_hold_b = hold_b;
		next_chain_data = chain_data;
		next_bit_q = bit_q;
		next_bit_valid = 1'b0;
		next_byte_q.data = byte_q.data;
		next_byte_q.valid = 1'b0;
		if (active && !i_byte_mode) begin
			if (clk_rise) begin
				next_hold_a = din_level;
				next_hold_b = hold_a;
				next_bit_q = din_level;
				next_bit_valid = 1'b1;
			end
			if (clk_fall) begin
				next_chain_data = hold_b;
			end
		end
		if (active && i_byte_mode && clk_rise && sel_level) begin
			next_byte_q.data = bus_level;
			next_byte_q.valid = 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (i_arst_n == CCP_RESET_LOW) begin
			hold_a <= 1'b0;
			hold_b <= 1'b0;
			chain_data <= 1'b0;
			bit_q <= 1'b0;
			bit_valid <= 1'b0;
			byte_q <= '0;
		end else begin
			hold_a <= next_hold_a;
			hold_b <= next_hold_b;
			chain_data <= next_chain_data;
			bit_q <= next_bit_q;
			bit_valid <= next_bit_valid;
			byte_q <= next_byte_q;
		end
	end

	// ----------------------------------------
	// Pin control
	// ----------------------------------------
	ccp_pin_s chain_pin;
	ccp_pin_s next_chain_pin;
	logic init_oe_n;
	logic next_init_oe_n;

	always_comb begin
		next_chain_pin.out = 1'b0;
		next_chain_pin.oe_n = CCP_OE_RELEASE;
		next_init_oe_n = CCP_OE_RELEASE;
		if (active) begin
			next_chain_pin.oe_n = CCP_OE_DRIVE;
			if (i_byte_mode) begin
				next_chain_pin.out = (state == CCP_PASS) && sel_level;
			end else begin
				next_chain_pin.out = chain_data;
			end
			if (i_data_error) begin
				next_init_oe_n = CCP_OE_DRIVE;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (i_arst_n == CCP_RESET_LOW) begin
			chain_pin <= '{out: 1'b0, oe_n: CCP_OE_RELEASE};
			init_oe_n <= CCP_OE_RELEASE;
		end else begin
			chain_pin <= next_chain_pin;
			init_oe_n <= next_init_oe_n;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	logic drive_six;
	assign drive_six = (VARIANT == CCP_VARIANT_EIGHT_GLOBAL);
	assign o_global_input_six = drive_six ? chain_pin.out : 1'b0;
	assign o_global_input_six_oe_n = drive_six ? chain_pin.oe_n : CCP_OE_RELEASE;
	assign o_secondary_global_input_four = drive_six ? 1'b0 : chain_pin.out;
	assign o_secondary_global_input_four_oe_n = drive_six ? CCP_OE_RELEASE : chain_pin.oe_n;
	assign o_init_n = 1'b0;
	assign o_init_oe_n = init_oe_n;
	assign o_pullup_en = (state != CCP_DONE);
	assign o_user_io_release = (state == CCP_DONE);
	assign o_bit = bit_q;
	assign o_bit_valid = bit_valid;
	assign o_byte = byte_q.data;
	assign o_byte_valid = byte_q.valid;
	assign o_busy = active;

endmodule // ccp_config_port

// ---- ccp_config_port_checker.sv ----
// Concurrent checks on the configuration port's top-level ports.
`timescale 1ns/1ps
module ccp_config_port_checker
	import ccp_pkg::*;
#(
	parameter logic VARIANT = CCP_VARIANT_EIGHT_GLOBAL
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_arst_n,
	// Watched inputs
	input wire logic i_byte_mode,
	input wire logic i_data_error,
	// Watched outputs
	input wire logic o_global_input_six_oe_n,
	input wire logic o_secondary_global_input_four_oe_n,
	input wire logic o_init_oe_n,
	input wire logic o_pullup_en,
	input wire logic o_user_io_release,
	input wire logic o_bit_valid,
	input wire logic o_byte_valid,
	input wire logic o_busy
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_arst_n);
	property p_pull;
		o_pullup_en != o_user_io_release;
	endproperty
	a_pull: assert property (p_pull) else $error("pull-up and release disagree");
	property p_chain_off;
		o_user_io_release |=> o_global_input_six_oe_n && o_secondary_global_input_four_oe_n;
	endproperty
	a_chain_off: assert property (p_chain_off) else $error("chain pin driven");
	property p_bit_pulse;
		o_bit_valid |=> !o_bit_valid;
	endproperty
	a_bit_pulse: assert property (p_bit_pulse) else $error("bit pulse too long");
	property p_bit_mode;
		o_bit_valid |-> !i_byte_mode && $past(o_busy);
	endproperty
	a_bit_mode: assert property (p_bit_mode) else $error("bit taken in wrong mode");
	property p_byte_mode;
		o_byte_valid |-> i_byte_mode && $past(o_busy);
	endproperty
	a_byte_mode: assert property (p_byte_mode) else $error("byte taken in wrong mode");
	property p_init_clear;
		!i_data_error |=> o_init_oe_n;
	endproperty
	a_init_clear: assert property (p_init_clear) else $error("init pulled low");
	property p_init_err;
		i_data_error && o_busy |=> !o_init_oe_n;
	endproperty
	a_init_err: assert property (p_init_err) else $error("error not reported");
	property p_unused;
		((VARIANT == CCP_VARIANT_EIGHT_GLOBAL) ? o_secondary_global_input_four_oe_n
			: o_global_input_six_oe_n) == CCP_OE_RELEASE;
	endproperty
	a_unused: assert property (p_unused) else $error("unused chain pin driven");
	c_bit: cover property (o_bit_valid);
	c_byte: cover property (o_byte_valid);
	c_done: cover property ($rose(o_user_io_release));
endmodule // ccp_config_port_checker
bind ccp_config_port ccp_config_port_checker #(.VARIANT(VARIANT)) u_chk (.*);

// ---- ccp_source_model.sv ----
// Configuration source model driving the port's pins.
`timescale 1ns/1ps
module ccp_source_model (
	// Pins
	output logic o_config_clock,
	output logic o_sdata,
	output logic o_csel,
	output logic [7:0] o_bus
);
	initial begin
		o_config_clock = 1'b0;
		o_sdata = 1'b0;
		o_csel = 1'b0;
		o_bus = 8'h00;
	end
	// Sets up data and select, then raises the clock.
	task automatic rise(input logic b, input logic [7:0] v, input logic s);
		o_sdata = b;
		o_bus = v;
		o_csel = s;
		#40 o_config_clock = 1'b1;
	endtask
	// Changes the chain select alone, with the clock standing still.
	task automatic select(input logic s);
		o_csel = s;
	endtask
	// Lowers the clock; held data then turns to its inverse.
	task automatic fall();
		#40 o_config_clock = 1'b0;
		o_sdata = ~o_sdata;
		o_bus = ~o_bus;
	endtask
endmodule // ccp_source_model

// ---- test_ccp_config_port.sv ----
// Self-checking bench for the configuration port.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
	$display("mismatch at %0t: %h vs %h", $time, a, b); end end
module test_ccp_config_port;
	import ccp_pkg::*;
	logic mclk, rst_n, start, bm, ol, cd, de, chain, chain_oe_n, init_n, init_oe_n;
	logic pull, rel, bit_q, bit_v, byte_v, busy, config_clock, sd, cs, sec, sec_oe_n;
	logic [7:0] bus, byte_q;
	logic [8:0] rows [4] = '{9'h1A5, 9'h15A, 9'h0FF, 9'h100};
	logic bits [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	int tests_run = 0, bad_count = 0, nbit = 0, nbyte = 0, n0;
	ccp_source_model src (.o_config_clock(config_clock), .o_sdata(sd), .o_csel(cs), .o_bus(bus));
	ccp_config_port dut (.i_mclk(mclk), .i_arst_n(rst_n), .i_start(start), .i_byte_mode(bm),
		.i_own_loaded(ol), .i_config_done(cd), .i_data_error(de), .i_config_clock(config_clock),
		.i_serial_data(sd), .i_chain_select_in(cs), .i_config_byte_bus(bus),
		.o_global_input_six(chain), .o_global_input_six_oe_n(chain_oe_n),
		.o_secondary_global_input_four(sec), .o_secondary_global_input_four_oe_n(sec_oe_n),
		.o_init_n(init_n), .o_init_oe_n(init_oe_n), .o_pullup_en(pull),
		.o_user_io_release(rel), .o_bit(bit_q), .o_bit_valid(bit_v), .o_byte(byte_q),
		.o_byte_valid(byte_v), .o_busy(busy));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (bit_v === 1'b1) nbit++;
		if (byte_v === 1'b1) nbyte++;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic test_done();
		$display("counts: %0d run, %0d bad", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		test_done();
	end
	initial begin
		{rst_n, start, bm, ol, cd, de} = 6'h00;
		tick(8);
		`CHK(pull, 1'b1)
		`CHK(chain_oe_n, 1'b1)
		`CHK({rel, busy}, 2'h0)
		rst_n = 1'b1;
		start = 1'b1;
		bm = 1'b1;
		tick(2);
		$display("reset test done");
		foreach (rows[i]) begin
			n0 = nbyte;
			src.rise(1'b0, rows[i][7:0], rows[i][8]);
			src.fall();
			tick(8);
			`CHK(nbyte - n0, int'(rows[i][8]))
			if (rows[i][8]) `CHK(byte_q, rows[i][7:0])
			`CHK(chain, 1'b0)
		end
		$display("byte rows done");
		ol = 1'b1;
		for (int s = 1; s >= 0; s--) begin
			src.select(s[0]);
			tick(8);
			`CHK(chain, s[0])
			`CHK(chain_oe_n, CCP_OE_DRIVE)
			`CHK({sec, sec_oe_n}, 2'h1)
		end
		$display("status test done");
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
		bm = 1'b0;
		tick(2);
		foreach (bits[i]) begin
			n0 = nbit;
			src.rise(bits[i], 8'h00, 1'b0);
			tick(8);
			if (i > 1) `CHK(chain, bits[i-2])
			src.fall();
			tick(8);
			`CHK(nbit - n0, 1)
			`CHK(bit_q, bits[i])
			if (i > 0) `CHK(chain, bits[i-1])
		end
		$display("serial test done");
		de = 1'b1;
		tick(2);
		`CHK({init_n, init_oe_n}, 2'h0)
		de = 1'b0;
		tick(2);
		`CHK(init_oe_n, 1'b1)
		$display("error test done");
		cd = 1'b1;
		tick(2);
		`CHK({rel, pull, busy}, 3'h4)
		`CHK(chain_oe_n, 1'b1)
		`CHK(sec_oe_n, 1'b1)
		n0 = nbit;
		src.rise(1'b1, 8'h3C, 1'b1);
		src.fall();
		tick(8);
		`CHK(nbit - n0, 0)
		$display("done test done");
		test_done();
	end
endmodule // test_ccp_config_port
